// file: design/pcd_defines.vh
`ifndef PCD_DEFINES_VH
`define PCD_DEFINES_VH
`define PCD_NPINS 6
`define PCD_ADDR_RISE 8'h00
`define PCD_ADDR_FALL 8'h04
`define PCD_ADDR_FLAGS 8'h08
`define PCD_ADDR_CTRL 8'h0C
`define PCD_ADDR_IRQ_STAT 8'h10
`define PCD_ADDR_IRQ_MASK 8'h14
`define PCD_CTRL_MASTER_BIT 0
`define PCD_CTRL_SUMMARY_BIT 1
`define PCD_CTRL_SLEEP_BIT 2
`define PCD_STAT_EDGE_BIT 0
`define PCD_STAT_WAKE_BIT 1
`define PCD_EN_RESET 6'h00
`define PCD_FLAGS_RESET 6'h00
`define PCD_SYNC_STAGES 3
`endif

// file: design/pcd_sync.v
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module pcd_sync (
	clk,
	rst,
	pin_in,
	level_out
);
	input wire clk;
	input wire rst;
	input wire pin_in;
	output reg level_out;
	reg s1_r;
	reg s2_r;
	reg s3_r;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_out <= s3_r;
			end
		end
	end
endmodule // pcd_sync

// file: design/pcd_pin_change_detect.v
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pcd_defines.vh"
// What this block does
// (R1) per-pin rising detector gated by rising enable
// (R2) per-pin falling detector gated by falling enable
// (R3) both enables set detect either edge
// (R4) any pin combination may raise interrupt
// (R5) master off: flags still set, no change_irq_out; irq_out still follows unmasked status
// (R6) enabled edge sets flag, interrupts if master
// (R7) summary flag is OR of pin flags
// (R8) writing zero clears a pin flag
// (R9) edge during clear write keeps flag set
// (R10) software clears only bits seen set
// (R11) master enabled edge wakes from sleep
// (R12) sleep edge flagged before first instruction
// (R13) rising enable bits 5:0 rw, 7:6 zero
// (R14) falling enable bits 5:0 rw, 7:6 zero
// (R15) flags set by enabled edge, reset zero
// (R16) pins synchronised, edge from sample compare
// (R17) flags sticky until cleared or reset
module pcd_pin_change_detect (
	clk,
	rst,
	first_port_pin,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hwdata,
	hready,
	hreadyout,
	hresp,
	hrdata,
	change_irq_out,
	wake_out,
	irq_out
);
	input wire clk;
	input wire rst;
	input wire [5:0] first_port_pin;
	input wire hsel;
	input wire [7:0] haddr;
	input wire [1:0] htrans;
	input wire hwrite;
	input wire [2:0] hsize;
	input wire [31:0] hwdata;
	input wire hready;
	output reg hreadyout;
	output reg hresp;
	output reg [31:0] hrdata;
	output reg change_irq_out;
	output reg wake_out;
	output reg irq_out;

	wire [5:0] pin_sync;
	reg [5:0] pin_prev_r;
	reg [5:0] rise_en_r;
	reg [5:0] fall_en_r;
	reg [5:0] flags_r;
	wire [5:0] flags_nxt;
	reg master_en_r;
	reg sleep_r;
	reg sleep_nxt;
	reg [1:0] irq_stat_r;
	reg [1:0] irq_stat_nxt;
	reg [1:0] irq_mask_r;
	reg wr_pend_r;
	reg [7:0] wr_addr_r;
	reg [31:0] rd_data;

	wire [5:0] rise_evt;
	wire [5:0] fall_evt;
	wire [5:0] edge_evt;
	wire any_edge;
	wire summary;
	wire wake_evt;
	wire req_take;
	wire rd_take;
	wire wr_take;
	wire wr_fire;
	wire wr_rise;
	wire wr_fall;
	wire wr_flags;
	wire wr_ctrl;
	wire wr_stat;
	wire wr_mask;
	wire [5:0] wr_low6;
	wire [1:0] wr_low2;

	// hsize is ignored: every register is one whole word
	assign req_take = hsel & hready & htrans[1];
	assign rd_take = req_take & ~hwrite;
	assign wr_take = req_take & hwrite;
	assign wr_fire = wr_pend_r;
	assign wr_low6 = hwdata[5:0];
	assign wr_low2 = hwdata[1:0];

	// decode off the captured address, since hwdata only stands a cycle later
	assign wr_rise = wr_fire & (wr_addr_r == `PCD_ADDR_RISE);
	assign wr_fall = wr_fire & (wr_addr_r == `PCD_ADDR_FALL);
	assign wr_flags = wr_fire & (wr_addr_r == `PCD_ADDR_FLAGS);
	assign wr_ctrl = wr_fire & (wr_addr_r == `PCD_ADDR_CTRL);
	assign wr_stat = wr_fire & (wr_addr_r == `PCD_ADDR_IRQ_STAT);
	assign wr_mask = wr_fire & (wr_addr_r == `PCD_ADDR_IRQ_MASK);

	// one synchroniser, two edge detectors and one flag input per pin
	genvar i;
	generate
		for (i = 0; i < `PCD_NPINS; i = i + 1) begin : g_pin
			pcd_sync u_sync (
				.clk(clk),
				.rst(rst),
				.pin_in(first_port_pin[i]),
				.level_out(pin_sync[i])
			);
			assign rise_evt[i] = rise_en_r[i] & pin_sync[i] & ~pin_prev_r[i]; // (R1) (R3)
			assign fall_evt[i] = fall_en_r[i] & ~pin_sync[i] & pin_prev_r[i]; // (R2) (R3)
			assign edge_evt[i] = rise_evt[i] | fall_evt[i]; // (R15)
			// a written zero clears, but an edge in the same cycle wins
			assign flags_nxt[i] = edge_evt[i] | (flags_r[i] & ~(wr_flags & ~wr_low6[i])); // (R8) (R9) (R17)
		end
	endgenerate

	assign any_edge = |edge_evt;
	assign summary = |flags_r; // (R7)
	assign wake_evt = sleep_r & master_en_r & any_edge; // (R11)

	// previous synchronised sample for edge compare
	// pins rest low after reset, so a pin held high gives one rising edge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_prev_r <= 6'h00;
		end else begin
			pin_prev_r <= pin_sync; // (R16)
		end
	end

	// address phase is captured; the write lands in the data phase
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_pend_r <= 1'b0;
		end else begin
			wr_pend_r <= wr_take;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_addr_r <= 8'h00;
		end else begin
			if (req_take) begin
				wr_addr_r <= haddr;
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rise_en_r <= `PCD_EN_RESET;
		end else begin
			if (wr_rise) begin
				rise_en_r <= wr_low6; // (R13)
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fall_en_r <= `PCD_EN_RESET;
		end else begin
			if (wr_fall) begin
				fall_en_r <= wr_low6; // (R14)
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			master_en_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				master_en_r <= hwdata[`PCD_CTRL_MASTER_BIT];
			end
		end
	end

	// sleep is a software bit; a CTRL write of zero or a wake with master enable ends it
	always @* begin
		sleep_nxt = sleep_r;
		if (wr_ctrl) begin
			sleep_nxt = hwdata[`PCD_CTRL_SLEEP_BIT];
		end
		if (wake_evt) begin
			sleep_nxt = 1'b0; // (R11)
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_r <= 1'b0;
		end else begin
			sleep_r <= sleep_nxt;
		end
	end

	// mask bits only gate irq_out; status keeps recording
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_mask_r <= 2'h0;
		end else begin
			if (wr_mask) begin
				irq_mask_r <= wr_low2;
			end
		end
	end

	// flags load every cycle, so an edge never waits on a bus cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_r <= `PCD_FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt; // (R12) (R15)
		end
	end

	// bit 0 any enabled edge, bit 1 wake; a set beats a write-one clear
	always @* begin
		irq_stat_nxt = irq_stat_r;
		if (wr_stat) begin
			irq_stat_nxt = irq_stat_r & ~wr_low2;
		end
		irq_stat_nxt[`PCD_STAT_EDGE_BIT] = irq_stat_nxt[`PCD_STAT_EDGE_BIT] | any_edge;
		irq_stat_nxt[`PCD_STAT_WAKE_BIT] = irq_stat_nxt[`PCD_STAT_WAKE_BIT] | wake_evt;
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_stat_r <= 2'h0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// decoded from the address phase, registered for the data phase
	always @* begin
		rd_data = 32'h00000000;
		case (haddr)
			`PCD_ADDR_RISE: rd_data = {26'h0, rise_en_r}; // (R13)
			`PCD_ADDR_FALL: rd_data = {26'h0, fall_en_r}; // (R14)
			`PCD_ADDR_FLAGS: rd_data = {26'h0, flags_r};
			`PCD_ADDR_CTRL: rd_data = {29'h0, sleep_r, summary, master_en_r}; // (R7)
			`PCD_ADDR_IRQ_STAT: rd_data = {30'h0, irq_stat_r};
			`PCD_ADDR_IRQ_MASK: rd_data = {30'h0, irq_mask_r};
			default: rd_data = 32'h00000000;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else begin
			if (rd_take) begin
				hrdata <= rd_data;
			end
		end
	end

	// zero wait states: ready always high, response always okay
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// change interrupt lags the flags by one cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			change_irq_out <= 1'b0;
		end else begin
			change_irq_out <= master_en_r & summary; // (R4) (R5) (R6)
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_out <= 1'b0;
		end else begin
			wake_out <= wake_evt; // (R11)
		end
	end

	// level output: high while any unmasked status bit is set
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(irq_stat_r & irq_mask_r);
		end
	end
endmodule // pcd_pin_change_detect

// file: sim/pcd_pin_src.sv
`timescale 1ns/1ps
// outside world: pin levels move just after an edge, never on it
module pcd_pin_src (
	input wire clk,
	input wire [5:0] level,
	output reg [5:0] pins
);
	initial pins = 6'h00;
	always @(posedge clk)
		pins <= level;
endmodule // pcd_pin_src

// file: sim/pcd_properties.sv
`timescale 1ns/1ps
module pcd_properties (
	input wire clk,
	input wire rst,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire change_irq_out,
	input wire wake_out,
	input wire irq_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire take = hsel && hready && htrans[1];
	wire rd = take && !hwrite;
	reg wr_ctrl_r;
	reg master_r;
	// shadow of the master enable, tracked from bus writes
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ctrl_r <= 1'b0;
			master_r <= 1'b0;
		end else begin
			wr_ctrl_r <= take && hwrite && haddr == 8'h0C;
			if (wr_ctrl_r)
				master_r <= hwdata[0];
		end
	end
	property p_ok; hreadyout && !hresp; endproperty
	a_ok: assert property (p_ok) else $error("bus not ready");
	property p_bits; rd && haddr < 8'h0C |=> hrdata[31:6] == 26'h0; endproperty
	a_bits: assert property (p_bits) else $error("upper bits set");
	property p_hold; !rd |=> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_master; !master_r && !$past(master_r) |-> !change_irq_out; endproperty
	a_master: assert property (p_master) else $error("irq while off");
	property p_pulse; wake_out |=> !wake_out; endproperty
	a_pulse: assert property (p_pulse) else $error("wake too long");
	property p_wake; wake_out |-> master_r || $past(master_r); endproperty
	a_wake: assert property (p_wake) else $error("wake while off");
	property p_sticky; $fell(change_irq_out) |-> $past(take && hwrite, 3); endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");
	property p_irq; $fell(irq_out) |-> $past(take && hwrite, 3); endproperty
	a_irq: assert property (p_irq) else $error("irq dropped");
	c_wake: cover property (wake_out);
	c_chg: cover property (change_irq_out);
	c_irq: cover property (irq_out);
endmodule // pcd_properties

// file: sim/pcd_pin_change_detect_tb.sv
`timescale 1ns/1ps
module pcd_pin_change_detect_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg hsel = 1'b0;
	reg [7:0] haddr = 8'h00;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg [5:0] lvl = 6'h00;
	reg [31:0] rd;
	integer fails = 0;
	integer tests_run = 0;
	integer nw;
	wire [5:0] pins;
	wire hrdy;
	wire hresp;
	wire [31:0] hrdata;
	wire cirq;
	wire wake;
	wire irq;
	always #5 clk = ~clk;
	pcd_pin_src pcd_pin_src_i (.clk(clk), .level(lvl), .pins(pins));
	pcd_pin_change_detect pcd_pin_change_detect_i (.clk(clk), .rst(rst), .first_port_pin(pins),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata),
		.change_irq_out(cirq), .wake_out(wake), .irq_out(irq));
	task results;
		begin
			$display("compares %0d mismatches %0d", tests_run, fails);
			if (fails == 0 && tests_run > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task rdy;
		integer n;
		begin
			n = 0;
			@(posedge clk);
			while (hrdy !== 1'b1) begin
				n = n + 1;
				if (n > 20) begin
					fails = fails + 1;
					results;
				end
				@(posedge clk);
			end
		end
	endtask
	task bus(input [7:0] a, input w, input [31:0] d);
		begin
			hsel <= 1'b1;
			haddr <= a;
			hwrite <= w;
			htrans <= 2'h2;
			rdy;
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			rdy;
			rd = hrdata;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task rc(input [7:0] a, input [31:0] e);
		begin
			bus(a, 1'b0, 32'h0);
			chk(rd, e);
		end
	endtask
	// sample on the falling edge so registered outputs have settled
	task pin(input [5:0] v);
		begin
			nw = 0;
			lvl <= v;
			repeat (12) begin
				@(negedge clk);
				if (wake === 1'b1)
					nw = nw + 1;
			end
			@(posedge clk);
		end
	endtask
	task t_regs;
		begin
			rc(8'h00, 32'h0);
			rc(8'h04, 32'h0);
			rc(8'h08, 32'h0);
			bus(8'h00, 1'b1, 32'hFF);
			rc(8'h00, 32'h3F);
			bus(8'h04, 1'b1, 32'hFF);
			rc(8'h04, 32'h3F);
			rc(8'h20, 32'h0);
			bus(8'h00, 1'b1, 32'h05);
			bus(8'h04, 1'b1, 32'h06);
			$display("registers done");
		end
	endtask
	task t_edges;
		begin
			pin(6'h3F);
			rc(8'h08, 32'h05);
			chk({31'h0, cirq}, 32'h0);
			bus(8'h08, 1'b1, 32'h0);
			rc(8'h08, 32'h0);
			pin(6'h00);
			rc(8'h08, 32'h06);
			bus(8'h08, 1'b1, 32'h3D);
			rc(8'h08, 32'h04);
			$display("edges done");
		end
	endtask
	task t_irq;
		begin
			bus(8'h0C, 1'b1, 32'h1);
			rc(8'h0C, 32'h3);
			chk({31'h0, cirq}, 32'h1);
			rc(8'h10, 32'h1);
			bus(8'h14, 1'b1, 32'h1);
			rc(8'h14, 32'h1);
			chk({31'h0, irq}, 32'h1);
			bus(8'h10, 1'b1, 32'h1);
			bus(8'h08, 1'b1, 32'h0);
			rc(8'h10, 32'h0);
			chk({30'h0, irq, cirq}, 32'h0);
			$display("interrupts done");
		end
	endtask
	// rising enables 05 and pins 00 to 3D: pins 0 and 2 rise together
	task t_wake;
		begin
			bus(8'h0C, 1'b1, 32'h5);
			pin(6'h3D);
			chk(nw, 32'h1);
			rc(8'h08, 32'h05);
			rc(8'h0C, 32'h3);
			rc(8'h10, 32'h3);
			$display("wake done");
		end
	endtask
	// pin 2 falls so that its flag sets at the data edge of a clearing write
	task t_race;
		begin
			bus(8'h08, 1'b1, 32'h0);
			rc(8'h08, 32'h0);
			lvl <= 6'h39;
			repeat (4) @(posedge clk);
			bus(8'h08, 1'b1, 32'h0);
			rc(8'h08, 32'h04);
			$display("race done");
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_edges;
		t_irq;
		t_wake;
		t_race;
		results;
	end
endmodule // pcd_pin_change_detect_tb
bind pcd_pin_change_detect pcd_properties pcd_properties_i (.clk(clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .change_irq_out(change_irq_out),
	.wake_out(wake_out), .irq_out(irq_out));
